// file: fdc_cfg.svh
// flash driver control: offsets, field positions, reset values, timing
// assumes inclusion by fdc_top.sv, fdc_timer.sv and the testbench
`ifndef FDC_CFG_SVH
`define FDC_CFG_SVH

// ************************************************************
// register offsets
// ************************************************************
`define FDC_ADDR_GP 8'h10
`define FDC_ADDR_CUR 8'ha0
`define FDC_ADDR_OPT 8'hb0
`define FDC_ADDR_HI 8'hc0
`define FDC_ADDR_LO 8'hd0

// ************************************************************
// power-on values
// ************************************************************
`define FDC_RST_GP 8'h00
`define FDC_RST_CUR 8'hf8
`define FDC_RST_OPT 8'h80
`define FDC_RST_HI 8'hf9
`define FDC_RST_LO 8'hc6

// ************************************************************
// field positions
// ************************************************************
`define FDC_GP_TORCH 0
`define FDC_GP_CHARGE 1
`define FDC_GP_FLASH 2
`define FDC_GP_LVL_LO 3
`define FDC_GP_LVL_HI 4
`define FDC_GP_GATE 5
`define FDC_GP_SENSE 6
`define FDC_GP_IND 7
`define FDC_CUR_TORCH_LSB 0
`define FDC_CUR_FLASH_LSB 3
`define FDC_OPT_DUR_LSB 0
`define FDC_OPT_STRB 4
`define FDC_OPT_OH_LSB 5
`define FDC_THR_W 6

// ************************************************************
// timing
// ************************************************************
`define FDC_CLK_MHZ 125
`define FDC_STEP_MS 16
`define FDC_LONG_MS 512
`define FDC_STEP_CYCLES (`FDC_STEP_MS * `FDC_CLK_MHZ * 1000)
`define FDC_LONG_STEPS (`FDC_LONG_MS / `FDC_STEP_MS)

`endif

// file: fdc_host.sv
// host model: serial engine side of the register bus
// assumes one clock; drives just after falling edges
`timescale 1ns/1ps

module fdc_host
(
  input wire logic clk,
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata
);
  // idle bus from time zero
  initial
  begin
    reg_wr = 1'h0;
    reg_rd = 1'h0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end

  // one access held across the taking edge; released lines show junk
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_wr = w;
    reg_rd = !w;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clk);
    reg_wr = 1'h0;
    reg_rd = 1'h0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask : acc
endmodule : fdc_host

// file: fdc_pkg.sv
// flash driver control: shared types
// assumes nothing beyond a SystemVerilog compiler
package fdc_pkg;

  // ************************************************************
  // flash sequencer states
  // ************************************************************
  typedef enum logic [2:0]
  {
    FDC_IDLE = 3'b001,
    FDC_FIRE = 3'b010,
    FDC_DONE = 3'b100
  } fdc_state_e;

  // ************************************************************
  // state of the top module
  // ************************************************************
  typedef struct packed
  {
    logic [7:0] gp;
    logic [7:0] cur;
    logic [7:0] opt;
    logic [7:0] hi;
    logic [7:0] lo;
    logic [7:0] rdata;
    logic [3:0] s1;
    logic [3:0] s2;
    logic [3:0] s3;
    logic [3:0] filt;
    logic strb_prev;
    fdc_state_e st;
  } fdc_top_s;

  // ************************************************************
  // state of the time-out timer
  // ************************************************************
  typedef struct packed
  {
    logic run;
    logic [31:0] presc;
    logic [5:0] steps;
    logic [5:0] target;
    logic expired;
  } fdc_tmr_s;

endpackage : fdc_pkg

// file: fdc_timer.sv
// flash time-out timer: counts 16 ms steps up to the selected duration
// assumes a start pulse on flash entry and a stop pulse on flash exit
`timescale 1ns/1ps
`include "fdc_cfg.svh"

module fdc_timer
#(
  parameter int unsigned STEP_CYCLES = `FDC_STEP_CYCLES
)
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic start,
  input wire logic stop,
  input wire logic [3:0] dur_code,
  output logic expired
);

  fdc_pkg::fdc_tmr_s q;
  fdc_pkg::fdc_tmr_s d;

  // ************************************************************
  // next state
  // ************************************************************
  // prescaler makes one step per 16 ms, steps count to the target
  always_comb
  begin
    d = q;
    d.expired = 1'b0;
    if (start)
    begin
      d.run = 1'b1;
      d.presc = 32'h0;
      d.steps = 6'h0;
      // codes 0..14 give k+1 steps, all-ones gives the long time
      if (dur_code == 4'hf)
        d.target = 6'(`FDC_LONG_STEPS);
      else
        d.target = 6'(dur_code) + 6'h1;
    end
    else if (stop)
      d.run = 1'b0;
    else if (q.run)
    begin
      if (q.presc == STEP_CYCLES - 1)
      begin
        d.presc = 32'h0;
        d.steps = q.steps + 6'h1;
        if (q.steps + 6'h1 == q.target)
        begin
          d.run = 1'b0;
          d.expired = 1'b1; // ends flash on time-out
        end
      end
      else
        d.presc = q.presc + 32'h1;
    end
  end

  // state register
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      q <= '0;
    else
      q <= d;
  end

  assign expired = q.expired;

endmodule : fdc_timer

// file: fdc_top.sv
// flash driver control registers, mode decode and flash sequencing
// assumes the serial bus engine drives reg_wr/reg_rd with address and data,
// and that comparators outside report charge and sense levels
//
// What this block does
// - mode bits: 000 off, 001 torch, 010 charge, 011 both, 1xx flash.
// - charge level bits 4:3 pick optimal, 4.5, 5.0 or 5.3 V target.
// - gating bit clear: no flash until end of charge reached.
// - gating bit set: flash may start without end of charge.
// - bit 6 enables sensing; when clear sensing never alters current.
// - bit 7 turns the indicator source on, zero turns it off.
// - torch code: 60 mA at zero, 20 mA steps, 200 mA at seven.
// - flash code: 30 mV at zero, 10 mV steps, 100 mV at seven.
// - strobe select zero means edge trigger, one means level follow.
// - duration code k gives 16 ms times k+1; all ones gives 512 ms.
// - overhead code: 300 mV at zero, 100 mV steps, up to 1 V.
// - sense threshold code N means trip at 1 V times N over 63.
// - end-of-charge flag in charge mode when target reached, 95% or optimal level.
// - sensing on and above lower trip: flash drops to 70%.
// - sensing on and above upper trip: no flash may start.
`timescale 1ns/1ps
`include "fdc_cfg.svh"

module fdc_top
#(
  parameter int unsigned STEP_CYCLES = `FDC_STEP_CYCLES
)
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic strobe,
  input wire logic charge_done,
  input wire logic above_upper,
  input wire logic above_lower,
  output logic mode_torch,
  output logic mode_charge,
  output logic mode_flash,
  output logic [1:0] charge_level,
  output logic eoc_flag,
  output logic sense_enable,
  output logic indicator_enable,
  output logic [2:0] torch_code,
  output logic [2:0] flash_fb_code,
  output logic [2:0] overhead_voltage_code,
  output logic [5:0] sense_upper_code,
  output logic [5:0] sense_lower_code,
  output logic flash_on,
  output logic flash_reduced
);

  fdc_pkg::fdc_top_s q;
  fdc_pkg::fdc_top_s d;
  logic expired;
  logic tmr_start;
  logic tmr_stop;
  logic strobe_f;
  logic eoc_ok;
  logic upper_f;
  logic lower_f;
  logic gate_bit;
  logic strobe_sensitivity_sel;
  logic start_req;
  logic allowed;

  // ************************************************************
  // decode of register fields
  // ************************************************************
  // mode is a pure function of the stored bits, so a write acts next cycle
  assign mode_flash = q.gp[`FDC_GP_FLASH];
  assign mode_torch = ~q.gp[`FDC_GP_FLASH] & q.gp[`FDC_GP_TORCH];
  assign mode_charge = ~q.gp[`FDC_GP_FLASH] & q.gp[`FDC_GP_CHARGE];
  assign charge_level = q.gp[`FDC_GP_LVL_HI:`FDC_GP_LVL_LO];
  assign gate_bit = q.gp[`FDC_GP_GATE];
  assign sense_enable = q.gp[`FDC_GP_SENSE];
  assign indicator_enable = q.gp[`FDC_GP_IND];
  assign torch_code = q.cur[`FDC_CUR_TORCH_LSB +: 3];
  assign flash_fb_code = q.cur[`FDC_CUR_FLASH_LSB +: 3];
  assign overhead_voltage_code = q.opt[`FDC_OPT_OH_LSB +: 3];
  assign strobe_sensitivity_sel = q.opt[`FDC_OPT_STRB];
  assign sense_upper_code = q.hi[`FDC_THR_W-1:0];
  assign sense_lower_code = q.lo[`FDC_THR_W-1:0];
  assign reg_rdata = q.rdata;

  // filtered pin levels
  assign strobe_f = q.filt[0];
  assign eoc_ok = q.filt[1];
  assign upper_f = q.filt[2];
  assign lower_f = q.filt[3];

  // ************************************************************
  // flash qualification and outputs
  // ************************************************************
  // level mode follows the pin, edge mode fires on a rising edge
  assign start_req = strobe_sensitivity_sel ? strobe_f
                   : (strobe_f & ~q.strb_prev);
  // gating waits for charge; sensing above upper trip blocks start
  assign allowed = mode_flash & (gate_bit | eoc_ok)
                 & ~(sense_enable & upper_f);
  assign flash_on = (q.st == fdc_pkg::FDC_FIRE);
  assign flash_reduced = flash_on & sense_enable & lower_f;
  assign eoc_flag = mode_charge & eoc_ok;
  assign tmr_start = (q.st == fdc_pkg::FDC_IDLE)
                   & (d.st == fdc_pkg::FDC_FIRE);
  assign tmr_stop = flash_on & (d.st != fdc_pkg::FDC_FIRE);

  // ************************************************************
  // next state
  // ************************************************************
  always_comb
  begin
    d = q;
    // three-stage pin synchronisers, a change counts when stages agree
    d.s1 = {above_lower, above_upper, charge_done, strobe};
    d.s2 = q.s1;
    d.s3 = q.s2;
    d.filt = (~(q.s2 ^ q.s3) & q.s3) | ((q.s2 ^ q.s3) & q.filt);
    d.strb_prev = q.filt[0];
    // register writes, unmapped addresses ignored
    if (reg_wr)
    begin
      case (reg_addr)
        `FDC_ADDR_GP: d.gp = reg_wdata;
        `FDC_ADDR_CUR: d.cur = reg_wdata;
        `FDC_ADDR_OPT: d.opt = reg_wdata;
        `FDC_ADDR_HI: d.hi = reg_wdata;
        `FDC_ADDR_LO: d.lo = reg_wdata;
        default: d.gp = q.gp;
      endcase
    end
    // register reads, unmapped addresses return zero
    if (reg_rd)
    begin
      case (reg_addr)
        `FDC_ADDR_GP: d.rdata = q.gp;
        `FDC_ADDR_CUR: d.rdata = q.cur;
        `FDC_ADDR_OPT: d.rdata = q.opt;
        `FDC_ADDR_HI: d.rdata = q.hi;
        `FDC_ADDR_LO: d.rdata = q.lo;
        default: d.rdata = 8'h00;
      endcase
    end
    // flash sequencer
    case (q.st)
      fdc_pkg::FDC_IDLE:
      begin
        if (start_req & allowed)
          d.st = fdc_pkg::FDC_FIRE;
      end
      fdc_pkg::FDC_FIRE:
      begin
        if (!mode_flash)
          d.st = fdc_pkg::FDC_IDLE;
        else if (expired)
          d.st = fdc_pkg::FDC_DONE;
        else if (strobe_sensitivity_sel & ~strobe_f)
          d.st = fdc_pkg::FDC_IDLE;
      end
      fdc_pkg::FDC_DONE:
      begin
        // hold off until strobe drops so a held strobe cannot refire
        if (!mode_flash | !strobe_f)
          d.st = fdc_pkg::FDC_IDLE;
      end
      default: d.st = fdc_pkg::FDC_IDLE;
    endcase
  end

  // state register with power-on values
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      q <= '0;
      q.gp <= `FDC_RST_GP;
      q.cur <= `FDC_RST_CUR;
      q.opt <= `FDC_RST_OPT;
      q.hi <= `FDC_RST_HI;
      q.lo <= `FDC_RST_LO;
      q.st <= fdc_pkg::FDC_IDLE;
    end
    else
      q <= d;
  end

  // ************************************************************
  // time-out timer
  // ************************************************************
  fdc_timer
  #(
    .STEP_CYCLES(STEP_CYCLES)
  )
  u_timer
  (
    .clk(clk),
    .reset_n(reset_n),
    .start(tmr_start),
    .stop(tmr_stop),
    .dur_code(q.opt[`FDC_OPT_DUR_LSB +: 4]),
    .expired(expired)
  );

  // ************************************************************
  // checks
  // ************************************************************
  property p_mode_flash;
    @(posedge clk) disable iff (!reset_n)
    q.gp[`FDC_GP_FLASH] |-> mode_flash && !mode_torch && !mode_charge;
  endproperty
  a_mode_flash: assert property (p_mode_flash)
    else $error("flash bit did not override lower mode bits");

  property p_gate_hold;
    @(posedge clk) disable iff (!reset_n)
    $rose(flash_on) |-> $past(gate_bit | eoc_ok);
  endproperty
  a_gate_hold: assert property (p_gate_hold)
    else $error("flash started without charge while gated");

  property p_gate_open;
    @(posedge clk) disable iff (!reset_n)
    (q.st == fdc_pkg::FDC_IDLE) && start_req && mode_flash && gate_bit
      && !eoc_ok && !(sense_enable && upper_f) |=> flash_on;
  endproperty
  a_gate_open: assert property (p_gate_open)
    else $error("ungated flash did not start");

  property p_sense_off;
    @(posedge clk) disable iff (!reset_n)
    !sense_enable |-> !flash_reduced;
  endproperty
  a_sense_off: assert property (p_sense_off)
    else $error("sensing disabled yet current reduced");

  property p_write_next;
    @(posedge clk) disable iff (!reset_n)
    reg_wr && (reg_addr == `FDC_ADDR_GP)
      |=> indicator_enable == $past(reg_wdata[`FDC_GP_IND]);
  endproperty
  a_write_next: assert property (p_write_next)
    else $error("indicator did not follow write on next cycle");

  property p_timeout;
    @(posedge clk) disable iff (!reset_n)
    flash_on && expired && mode_flash
      |=> !flash_on && (q.st == fdc_pkg::FDC_DONE);
  endproperty
  a_timeout: assert property (p_timeout)
    else $error("flash continued after time-out");

  property p_level_follow;
    @(posedge clk) disable iff (!reset_n)
    flash_on && strobe_sensitivity_sel && !strobe_f |=> !flash_on;
  endproperty
  a_level_follow: assert property (p_level_follow)
    else $error("level strobe low but flash stayed on");

  property p_upper_block;
    @(posedge clk) disable iff (!reset_n)
    $rose(flash_on) |-> $past(!(sense_enable && upper_f));
  endproperty
  a_upper_block: assert property (p_upper_block)
    else $error("flash started above upper trip");

  property p_reduce;
    @(posedge clk) disable iff (!reset_n)
    flash_on && sense_enable && $past(above_lower, 3)
      && $past(above_lower, 4) |-> flash_reduced;
  endproperty
  a_reduce: assert property (p_reduce)
    else $error("current not reduced above lower trip");

  property p_eoc;
    @(posedge clk) disable iff (!reset_n)
    eoc_flag |-> mode_charge && $past(charge_done, 4);
  endproperty
  a_eoc: assert property (p_eoc)
    else $error("end of charge flagged without charge mode and target");

endmodule : fdc_top

// file: tb_flash_driver_control_registers.sv
// testbench of the flash driver control block with queued expectations
// assumes fdc_top with a short timer step and the host model beside it
`timescale 1ns/1ps
`include "fdc_cfg.svh"
`define TB_CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin \
  num_errors++; $display("[FAIL] %s exp %h got %h", n, e, g); end end

module tb_flash_driver_control_registers;
  localparam int STEP = 4;
  logic clk = 1'h0;
  logic reset_n = 1'h0;
  logic strobe = 1'h0, charge_done = 1'h0;
  logic above_upper = 1'h0, above_lower = 1'h0;
  logic reg_wr, reg_rd, mode_torch, mode_charge, mode_flash, eoc_flag;
  logic sense_enable, indicator_enable, flash_on, flash_reduced;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic [1:0] charge_level;
  logic [2:0] torch_code, flash_fb_code, overhead_voltage_code;
  logic [5:0] sense_upper_code, sense_lower_code;
  logic [28:0] obs;
  logic [33:0] q[$];
  logic [33:0] ent;
  logic [31:0] got, meas;
  logic rd_d = 1'h0, peek = 1'h0;
  logic [7:0] sh [0:4] = '{`FDC_RST_GP, `FDC_RST_CUR, `FDC_RST_OPT,
    `FDC_RST_HI, `FDC_RST_LO};
  logic [7:0] am [0:4] = '{`FDC_ADDR_GP, `FDC_ADDR_CUR, `FDC_ADDR_OPT,
    `FDC_ADDR_HI, `FDC_ADDR_LO};
  int num_errors = 0;
  int samples_checked = 0;
  int seed = 92075;
  int i, j, lo, hi;

  // ************************************************************
  // clock, design and host
  // ************************************************************
  always #4 clk = ~clk;

  fdc_top #(.STEP_CYCLES(STEP)) u_fdc_top
  (
    .clk(clk), .reset_n(reset_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .strobe(strobe), .charge_done(charge_done), .above_upper(above_upper),
    .above_lower(above_lower), .mode_torch(mode_torch),
    .mode_charge(mode_charge), .mode_flash(mode_flash),
    .charge_level(charge_level), .eoc_flag(eoc_flag),
    .sense_enable(sense_enable), .indicator_enable(indicator_enable),
    .torch_code(torch_code), .flash_fb_code(flash_fb_code),
    .overhead_voltage_code(overhead_voltage_code),
    .sense_upper_code(sense_upper_code), .sense_lower_code(sense_lower_code),
    .flash_on(flash_on), .flash_reduced(flash_reduced)
  );

  fdc_host u_fdc_host
  (
    .clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata)
  );

  // observed register-driven outputs, same order as exp_obs
  assign obs = {mode_torch, mode_charge, mode_flash, charge_level, eoc_flag,
    sense_enable, indicator_enable, torch_code, flash_fb_code,
    overhead_voltage_code, sense_upper_code, sense_lower_code};

  // ************************************************************
  // expectations and drivers
  // ************************************************************
  function automatic logic [28:0] exp_obs(input logic e);
    exp_obs = {sh[0][0] & !sh[0][2], sh[0][1] & !sh[0][2], sh[0][2],
      sh[0][4:3], e, sh[0][6], sh[0][7], sh[1][2:0], sh[1][5:3],
      sh[2][7:5], sh[3][5:0], sh[4][5:0]};
  endfunction : exp_obs

  task automatic w(input int k, input logic [7:0] d);
    sh[k] = d;
    u_fdc_host.acc(1'h1, am[k], d);
  endtask : w

  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    q.push_back({2'h0, 24'h000000, e});
    u_fdc_host.acc(1'h0, a, 8'h00);
    // let the read compare pass before any sample note is raised
    @(negedge clk);
  endtask : rchk

  // queue a note and let the monitor sample on the next rising edge
  task automatic note(input logic [33:0] e);
    q.push_back(e);
    peek = 1'h1;
    @(negedge clk);
    peek = 1'h0;
    @(negedge clk);
  endtask : note

  // set mode and comparators, raise strobe, count flash cycles
  task automatic fl(input logic [7:0] g, input logic [7:0] o,
    input logic cd, input logic au, input logic al, input int hold,
    input logic [15:0] n, input logic [15:0] r);
    int len, red, t;
    w(0, g);
    w(2, o);
    charge_done = cd;
    above_upper = au;
    above_lower = al;
    repeat (6) @(negedge clk);
    len = 0;
    red = 0;
    strobe = 1'h1;
    for (t = 0; t < 200; t++)
    begin
      @(negedge clk);
      if (t == hold)
        strobe = 1'h0;
      len += int'(flash_on === 1'h1);
      red += int'(flash_reduced === 1'h1);
    end
    strobe = 1'h0;
    repeat (8) @(negedge clk);
    meas = {len[15:0], red[15:0]};
    note({2'h2, n, r});
  endtask : fl

  task automatic stop_test();
    // a note never compared counts as a mismatch
    if (q.size() != 0)
      num_errors++;
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : stop_test

  // ************************************************************
  // monitor and watchdog
  // ************************************************************
  // compare the oldest note whenever a read or a sample comes due
  always @(posedge clk)
  begin
    rd_d <= reg_rd;
    if (rd_d || peek)
    begin
      if (q.size() == 0)
        num_errors++;
      else
      begin
        ent = q.pop_front();
        got = ent[33:32] == 2'h0 ? {24'h000000, reg_rdata} :
          ent[33:32] == 2'h1 ? {3'h0, obs} : meas;
        `TB_CHK("bus or output", ent[31:0], got)
      end
    end
  end

  // cut a hang short
  initial
  begin
    #(8 * 20000);
    num_errors++;
    stop_test();
  end

  // ************************************************************
  // scenarios
  // ************************************************************
  initial
  begin
    repeat (3) @(negedge clk);
    reset_n = 1'h1;
    for (i = 0; i < 5; i++)
      rchk(am[i], sh[i]);
    u_fdc_host.acc(1'h1, 8'h20, 8'hff);
    rchk(8'h20, 8'h00);
    rchk(am[0], 8'h00);
    note({2'h1, 3'h0, exp_obs(1'h0)});
    $display("test reset done");
    for (i = 0; i < 8; i++)
    begin
      w(0, {5'($random(seed)), 3'(i)});
      note({2'h1, 3'h0, exp_obs(1'h0)});
      rchk(am[0], sh[0]);
    end
    $display("test mode decode done");
    for (j = 0; j < 4; j++)
    begin
      w(1, 8'($random(seed)));
      w(2, 8'($random(seed)));
      lo = {$random(seed)} % 63;
      hi = lo + 1 + {$random(seed)} % (63 - lo);
      w(4, {2'($random(seed)), 6'(lo)});
      w(3, {2'($random(seed)), 6'(hi)});
      note({2'h1, 3'h0, exp_obs(1'h0)});
      for (i = 1; i < 5; i++)
        rchk(am[i], sh[i]);
    end
    $display("test codes done");
    charge_done = 1'h1;
    w(0, 8'h02);
    repeat (5) @(negedge clk);
    note({2'h1, 3'h0, exp_obs(1'h1)});
    w(0, 8'h01);
    note({2'h1, 3'h0, exp_obs(1'h0)});
    $display("test end of charge done");
    fl(8'h04, 8'h00, 1'h0, 1'h0, 1'h0, 12, 16'd0, 16'd0);
    fl(8'h04, 8'h00, 1'h1, 1'h0, 1'h0, 12, 16'd5, 16'd0);
    fl(8'h24, 8'h00, 1'h0, 1'h0, 1'h0, 12, 16'd5, 16'd0);
    fl(8'h24, 8'h01, 1'h0, 1'h0, 1'h0, 200, 16'd9, 16'd0);
    fl(8'h24, 8'h0f, 1'h0, 1'h0, 1'h0, 12, 16'd129, 16'd0);
    fl(8'h24, 8'h1f, 1'h0, 1'h0, 1'h0, 20, 16'd21, 16'd0);
    fl(8'h24, 8'h10, 1'h0, 1'h0, 1'h0, 30, 16'd5, 16'd0);
    fl(8'h64, 8'h00, 1'h0, 1'h1, 1'h1, 12, 16'd0, 16'd0);
    fl(8'h64, 8'h00, 1'h0, 1'h0, 1'h1, 12, 16'd5, 16'd5);
    fl(8'h24, 8'h00, 1'h0, 1'h1, 1'h1, 12, 16'd5, 16'd0);
    $display("test flash done");
    stop_test();
  end
endmodule : tb_flash_driver_control_registers
